// >>> logic/aof_encoder.sv
// Output word coding: format, randomizer, alternate bit polarity, test bypass
`timescale 1ns/1ps
`default_nettype none
module aof_encoder
    import aof_pkg::*;
(
    // Conversion result
    input  wire logic [AOF_DATA_W-1:0] raw,
    // Coding controls
    input  wire logic                  twos_en,
    input  wire logic                  rand_en,
    input  wire logic                  abp_en,
    // Test pattern override
    input  wire logic                  test_en,
    input  wire logic [AOF_DATA_W-1:0] test_word,
    // Coded word
    output logic      [AOF_DATA_W-1:0] coded
);
    logic [AOF_DATA_W-1:0] fmt;
    logic [AOF_DATA_W-1:0] rnd;

    always_comb begin
        fmt = raw;
        if (twos_en) begin
            fmt[AOF_DATA_W-1] = ~raw[AOF_DATA_W-1];
        end
        rnd = fmt;
        // Randomizer first so the receiver can strip the inversion before the XOR
        if (rand_en) begin
            rnd[AOF_DATA_W-1:1] = fmt[AOF_DATA_W-1:1] ^ {(AOF_DATA_W-1){fmt[0]}};
        end
        if (abp_en) begin
            rnd = rnd ^ AOF_ODD_MASK;
        end
        coded = test_en ? test_word : rnd;
    end
endmodule
`default_nettype wire

// >>> logic/aof_formatter.sv
// ADC output formatter: AHB-Lite registers, coding, output modes, forwarded clock
// Overview of operation
// - DDR CMOS: eight lanes, two bits each
// - DDR LVDS: eight lane pairs, flag, clock
// - LVDS current seven levels, default 3.5 mA
// - Internal termination doubles LVDS current
// - Overflow flag shares data pipeline latency
// - Full rate: data changes on clock fall
// - DDR: data changes on both clock edges
// - Clock delayed 0/45/90/135 degrees
// - Phase shift only with stabilizer enabled
// - Separate bit inverts both output clocks
// - Offset binary default; two's complement selectable
// - Two's complement flips only the MSB
// - Randomizer XORs LSB into upper bits
// - Randomizer and polarity independent enables
// - Full rate CMOS: sixteen separate pins
// - Mode by register or strap; no strap DDR CMOS
// - Test pattern bypasses all coding
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module aof_formatter
    import aof_pkg::*;
#(
    parameter logic EVEN_ON_FALL = 1'b1
)(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    // Converter core, sample clock domain
    input  wire logic                  sample_clk,
    input  wire logic [AOF_DATA_W-1:0] sample_data,
    input  wire logic                  sample_ovf,
    // Configuration straps
    input  wire logic                  strap_par_cfg,
    input  wire logic                  strap_lvds,
    input  wire logic                  strap_dcs,
    // Test pattern source, core clock domain
    input  wire logic                  test_pattern_en,
    input  wire logic [AOF_DATA_W-1:0] test_pattern_word,
    // Output pins
    output logic [AOF_DATA_W-1:0]      data_out,
    output logic [AOF_LANES-1:0]       paired_bits_lane,
    output logic                       overflow_flag,
    output logic                       fwd_clock_true,
    output logic                       fwd_clock_comp,
    // Output driver controls
    output logic                       lvds_mode,
    output logic                       lvds_term_en,
    output logic [7:0]                 lvds_drive_units,
    output logic                       dcs_en
);
    typedef struct packed {
        logic                  hready;
        logic                  resp;
        logic [31:0]           hrdata;
        logic                  wr_pend;
        logic [7:0]            wr_ofs;
        logic [AOF_CC_W-1:0]   cc;
        logic [AOF_OM_W-1:0]   om;
        logic [AOF_DF_W-1:0]   df;
        logic [2:0]            clk_sy;
        logic [AOF_DATA_W-1:0] dat_s1;
        logic [AOF_DATA_W-1:0] dat_s2;
        logic [1:0]            ovf_sy;
        logic [1:0]            par_sy;
        logic [1:0]            lvds_sy;
        logic [1:0]            dcs_sy;
        logic [AOF_PER_W-1:0]  cnt;
        logic [AOF_PER_W-1:0]  period;
        logic [AOF_DATA_W-1:0] word;
        logic [AOF_DATA_W-1:0] dout;
        logic [AOF_LANES-1:0]  lanes;
        logic                  ddr_q;
        logic                  ovf_o;
        logic                  clk_t;
        logic                  clk_c;
        logic                  lvds_o;
        logic                  term_o;
        logic [7:0]            drive_o;
        logic                  dcs_o;
    } aof_state_t;

    aof_state_t s_r;
    aof_state_t s_nxt;

    // Register decode: word aligned and inside the low page
    function automatic logic is_reg(input logic [31:0] a, input logic [7:0] ofs);
        return (a[31:8] == 24'h000000) && (a[7:0] == ofs);
    endfunction

    // Select one bit of every pair onto the lanes
    function automatic logic [AOF_LANES-1:0] lane_pick(input logic [AOF_DATA_W-1:0] w,
                                                      input logic odd);
        logic [AOF_LANES-1:0] l;
        for (int i = 0; i < AOF_LANES; i++) begin
            l[i] = w[2*i + int'(odd)];
        end
        return l;
    endfunction

    // Clock delay in core cycles: period * sel / 8
    function automatic logic [AOF_PER_W-1:0] ph_shift(input logic [AOF_PER_W-1:0] per,
                                                     input logic [1:0] sel);
        logic [AOF_PER_W+2:0] prod;
        prod = (AOF_PER_W+3)'(per) * (AOF_PER_W+3)'(sel);
        return prod[AOF_PER_W+2:AOF_PHASE_SH];
    endfunction

    // Effective configuration
    logic                  par;
    aof_mode_t             mode;
    logic                  dcs_eff;
    logic [1:0]            ph_sel;
    logic                  inv;
    logic [AOF_DF_W-1:0]   df_eff;
    logic [2:0]            cur_sel;
    logic                  term;
    logic [AOF_DATA_W-1:0] enc;

    always_comb begin
        par = s_r.par_sy[1];
        if (par) begin
            // Strap only offers full rate CMOS or LVDS
            mode = s_r.lvds_sy[1] ? AOF_DDR_LVDS : AOF_FULL_CMOS;
        end else begin
            unique case (s_r.om[AOF_OM_MODE_LSB +: 2])
                2'b01:   mode = AOF_DDR_CMOS;
                2'b11:   mode = AOF_DDR_LVDS;
                default: mode = AOF_FULL_CMOS;
            endcase
        end
        dcs_eff = par ? s_r.dcs_sy[1] : s_r.cc[AOF_CC_DCS];
        // Without the stabilizer the clock edges are not trusted for a shift
        ph_sel  = (!par && dcs_eff) ? s_r.cc[AOF_CC_PH_LSB +: 2] : 2'b00;
        inv     = par ? 1'b0 : s_r.cc[AOF_CC_INV];
        df_eff  = par ? AOF_DF_RST : s_r.df;
        cur_sel = par ? 3'h0 : s_r.om[AOF_OM_CUR_LSB +: 3];
        term    = par ? 1'b0 : s_r.om[AOF_OM_TERM];
    end

    aof_encoder u_enc (
        .raw       (s_r.dat_s2),
        .twos_en   (df_eff[AOF_DF_TWOS]),
        .rand_en   (df_eff[AOF_DF_RAND]),
        .abp_en    (df_eff[AOF_DF_ABP]),
        .test_en   (test_pattern_en),
        .test_word (test_pattern_word),
        .coded     (enc)
    );

    logic                 edge_s;
    logic [AOF_PER_W-1:0] cnt_n;
    logic [AOF_PER_W-1:0] half;
    logic [AOF_PER_W-1:0] shift;
    logic [AOF_PER_W-1:0] pos;
    logic [31:0]          status;
    logic [7:0]           cur;

    always_comb begin
        s_nxt = s_r;

        // Bus: zero wait state, write lands in the data phase
        s_nxt.hready  = 1'b1;
        s_nxt.resp    = 1'b0;
        s_nxt.wr_pend = 1'b0;
        if (s_r.wr_pend) begin
            if (is_reg(32'(s_r.wr_ofs), AOF_CLK_CTRL_OFS)) begin
                s_nxt.cc = hwdata[AOF_CC_W-1:0];
            end
            if (is_reg(32'(s_r.wr_ofs), AOF_OUT_MODE_OFS)) begin
                s_nxt.om = hwdata[AOF_OM_W-1:0];
            end
            if (is_reg(32'(s_r.wr_ofs), AOF_DATA_FMT_OFS)) begin
                s_nxt.df = hwdata[AOF_DF_W-1:0];
            end
        end

        // Sample clock edge recovery; stage 0 feeds stage 1 only
        s_nxt.clk_sy  = {s_r.clk_sy[1], s_r.clk_sy[0], sample_clk};
        s_nxt.dat_s1  = sample_data;
        s_nxt.dat_s2  = s_r.dat_s1;
        s_nxt.ovf_sy  = {s_r.ovf_sy[0], sample_ovf};
        s_nxt.par_sy  = {s_r.par_sy[0], strap_par_cfg};
        s_nxt.lvds_sy = {s_r.lvds_sy[0], strap_lvds};
        s_nxt.dcs_sy  = {s_r.dcs_sy[0], strap_dcs};
        edge_s = s_r.clk_sy[1] & ~s_r.clk_sy[2];

        // Sample period in core cycles, saturating for a stopped clock
        if (edge_s) begin
            cnt_n = '0;
            if (s_r.cnt != '1) begin
                s_nxt.period = s_r.cnt + 1'b1;
            end
        end else begin
            cnt_n = (s_r.cnt == '1) ? s_r.cnt : s_r.cnt + 1'b1;
        end
        s_nxt.cnt = cnt_n;
        half  = s_r.period >> 1;
        shift = ph_shift(s_r.period, ph_sel);

        // Forwarded clock: low for the first half period after the data change
        pos = (cnt_n >= shift) ? cnt_n - shift : cnt_n + s_r.period - shift;
        s_nxt.clk_t = ((s_r.period != '0) && (pos >= half)) ^ inv;
        s_nxt.clk_c = ~s_nxt.clk_t;

        // Data and flag leave together on the sample edge
        if (edge_s) begin
            s_nxt.word  = enc;
            s_nxt.ovf_o = s_r.ovf_sy[1];
            s_nxt.ddr_q = (mode != AOF_FULL_CMOS);
            if (mode == AOF_FULL_CMOS) begin
                s_nxt.dout  = enc;
                s_nxt.lanes = '0;
            end else begin
                s_nxt.dout  = '0;
                s_nxt.lanes = lane_pick(enc, ~EVEN_ON_FALL);
            end
        // Routing follows the mode latched at the sample edge, so a mode change
        // mid-period never drives both pin groups with data at once
        end else if (s_r.ddr_q && (half != '0) && (cnt_n == half)) begin
            s_nxt.lanes = lane_pick(s_r.word, EVEN_ON_FALL);
        end

        // Driver controls
        cur = AOF_CUR_TBL[cur_sel];
        s_nxt.lvds_o  = (mode == AOF_DDR_LVDS);
        s_nxt.term_o  = term;
        s_nxt.drive_o = term ? {cur[6:0], 1'b0} : cur;
        s_nxt.dcs_o   = dcs_eff;

        // Read data comes from the next state so a read after a write sees it
        status = '0;
        status[AOF_DATA_W-1:0]                = s_r.word;
        status[AOF_ST_OVF]                    = s_r.ovf_o;
        status[AOF_ST_PAR]                    = par;
        status[AOF_ST_MODE_LSB +: 2]          = mode;
        status[AOF_ST_PER_LSB +: AOF_PER_W]   = s_r.period;
        if (hsel && htrans[1] && hready) begin
            // Only the low byte is kept, so high addresses must not alias onto the page
            s_nxt.wr_pend = hwrite && (hsize == 3'b010) && (haddr[31:8] == 24'h000000);
            s_nxt.wr_ofs  = haddr[7:0];
            s_nxt.hrdata  = '0;
            if (!hwrite) begin
                if (is_reg(haddr, AOF_CLK_CTRL_OFS)) begin
                    s_nxt.hrdata[AOF_CC_W-1:0] = s_nxt.cc;
                end
                if (is_reg(haddr, AOF_OUT_MODE_OFS)) begin
                    s_nxt.hrdata[AOF_OM_W-1:0] = s_nxt.om;
                end
                if (is_reg(haddr, AOF_DATA_FMT_OFS)) begin
                    s_nxt.hrdata[AOF_DF_W-1:0] = s_nxt.df;
                end
                if (is_reg(haddr, AOF_STATUS_OFS)) begin
                    s_nxt.hrdata = status;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_r        <= '0;
            s_r.hready <= 1'b1;
            s_r.cc     <= AOF_CC_RST;
            s_r.om     <= AOF_OM_RST;
            s_r.df     <= AOF_DF_RST;
            s_r.clk_c  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout        = s_r.hready;
    assign hrdata           = s_r.hrdata;
    assign hresp            = s_r.resp;
    assign data_out         = s_r.dout;
    assign paired_bits_lane = s_r.lanes;
    assign overflow_flag    = s_r.ovf_o;
    assign fwd_clock_true   = s_r.clk_t;
    assign fwd_clock_comp   = s_r.clk_c;
    assign lvds_mode        = s_r.lvds_o;
    assign lvds_term_en     = s_r.term_o;
    assign lvds_drive_units = s_r.drive_o;
    assign dcs_en           = s_r.dcs_o;
endmodule
`default_nettype wire

// >>> logic/aof_pkg.sv
// Shared constants and types for the ADC output formatter
package aof_pkg;
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] AOF_CLK_CTRL_OFS = 8'h00;
    localparam logic [7:0] AOF_OUT_MODE_OFS = 8'h04;
    localparam logic [7:0] AOF_DATA_FMT_OFS = 8'h08;
    localparam logic [7:0] AOF_STATUS_OFS   = 8'h0C;

    // clock_control_register fields
    localparam int AOF_CC_DCS    = 0;
    localparam int AOF_CC_PH_LSB = 1;
    localparam int AOF_CC_INV    = 3;
    localparam int AOF_CC_W      = 4;

    // output_mode_register fields
    localparam int AOF_OM_MODE_LSB = 0;
    localparam int AOF_OM_CUR_LSB  = 2;
    localparam int AOF_OM_TERM     = 5;
    localparam int AOF_OM_W        = 6;

    // data_format_register fields
    localparam int AOF_DF_TWOS = 0;
    localparam int AOF_DF_RAND = 1;
    localparam int AOF_DF_ABP  = 2;
    localparam int AOF_DF_W    = 3;

    // Status register fields
    localparam int AOF_ST_OVF      = 16;
    localparam int AOF_ST_PAR      = 17;
    localparam int AOF_ST_MODE_LSB = 18;
    localparam int AOF_ST_PER_LSB  = 20;

    // Reset values
    localparam logic [AOF_CC_W-1:0] AOF_CC_RST = 4'h0;
    localparam logic [AOF_OM_W-1:0] AOF_OM_RST = 6'h00;
    localparam logic [AOF_DF_W-1:0] AOF_DF_RST = 3'h0;

    // Data path geometry
    localparam int AOF_DATA_W = 16;
    localparam int AOF_LANES  = 8;
    localparam int AOF_PER_W  = 12;
    localparam logic [AOF_DATA_W-1:0] AOF_ODD_MASK = 16'hAAAA;

    // Phase shift in eighths of the sample period (45 degree steps)
    localparam int AOF_PHASE_SH = 3;

    // LVDS drive current in 50 uA units, indexed by the current select code
    localparam logic [7:0] AOF_CUR_TBL [8] = '{8'h46, 8'h50, 8'h5A, 8'h3C,
                                              8'h32, 8'h2A, 8'h23, 8'h46};

    typedef enum logic [1:0] {
        AOF_FULL_CMOS = 2'b00,
        AOF_DDR_CMOS  = 2'b01,
        AOF_DDR_LVDS  = 2'b11
    } aof_mode_t;
endpackage

// >>> testbench/aof_formatter_sva.sv
// Port checker for the ADC output formatter
`timescale 1ns/1ps
`default_nettype none
module aof_formatter_sva
    import aof_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // Output pins
    input wire logic [15:0] data_out,
    input wire logic [7:0]  paired_bits_lane,
    input wire logic        fwd_clock_true,
    input wire logic        fwd_clock_comp,
    input wire logic        lvds_term_en,
    input wire logic [7:0]  lvds_drive_units
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic take;
    assign take = hsel && htrans[1] && hready;
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_unmap; take && !hwrite && haddr[31:8] != 0 |=> hrdata == 0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold; !take |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_pair; fwd_clock_comp == !fwd_clock_true; endproperty
    a_pair: assert property (p_pair) else $error("clock pair not complementary");
    property p_excl; data_out != 0 |-> paired_bits_lane == 0; endproperty
    a_excl: assert property (p_excl) else $error("both pin groups active");
    // The guard skips the edge where termination toggles; units and termination are registered in the same cycle
    property p_cur; $past(nrst) && !lvds_term_en && !$past(lvds_term_en) |->
        lvds_drive_units inside {8'h23, 8'h2A, 8'h32, 8'h3C, 8'h46, 8'h50, 8'h5A}; endproperty
    a_cur: assert property (p_cur) else $error("drive level not allowed");
    property p_term; $past(nrst) && lvds_term_en && $past(lvds_term_en) |->
        lvds_drive_units inside {8'h46, 8'h54, 8'h64, 8'h78, 8'h8C, 8'hA0, 8'hB4}; endproperty
    a_term: assert property (p_term) else $error("terminated drive not doubled");
endmodule
bind aof_formatter aof_formatter_sva i_aof_formatter_sva (.*);
`default_nettype wire

// >>> testbench/aof_formatter_tb_top.sv
// Self-checking bench for the ADC output formatter
`timescale 1ns/1ps
`default_nettype none
module aof_formatter_tb_top
    import aof_pkg::*;
;
    logic core_clk = 0, nrst = 0, sample_clk = 0, hsel = 0, hwrite = 0, ovf = 0, tpe = 0;
    logic par = 0, lvds = 0, dcs = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0, rx_fmt = 0;
    logic [15:0] smp = 0, tpw = 0, data_out, rx_coded, rx_raw, rx_cnt;
    logic [7:0] lanes, units;
    logic hreadyout, hresp, oflag, clk_t, clk_c, lvds_mode, term, dcs_en, rx_ddr = 0, rx_ovf;
    int num_errors = 0, checks = 0;
    always #5 core_clk = ~core_clk;
    always #62.5 sample_clk = ~sample_clk;
    aof_formatter i_aof_formatter (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .sample_clk(sample_clk), .sample_data(smp), .sample_ovf(ovf), .strap_par_cfg(par),
        .strap_lvds(lvds), .strap_dcs(dcs), .test_pattern_en(tpe), .test_pattern_word(tpw),
        .data_out(data_out), .paired_bits_lane(lanes), .overflow_flag(oflag),
        .fwd_clock_true(clk_t), .fwd_clock_comp(clk_c), .lvds_mode(lvds_mode),
        .lvds_term_en(term), .lvds_drive_units(units), .dcs_en(dcs_en));
    aof_rx_model i_aof_rx_model (.core_clk(core_clk), .nrst(nrst), .ddr(rx_ddr), .fmt(rx_fmt),
        .data_out(data_out), .lanes(lanes), .ovf(oflag), .clk_t(clk_t), .rx_coded(rx_coded),
        .rx_raw(rx_raw), .rx_ovf(rx_ovf), .rx_cnt(rx_cnt));
    task automatic give_verdict();
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
            if (n >= 50) begin num_errors++; give_verdict(); end
            if (p == 0) begin htrans <= 2'h0; hsel <= 1'b0; hwdata <= d; end
        end
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask
    task automatic rd_cmp(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        cmp(nm, e, q);
    endtask
    task automatic words(input int k);
        logic [15:0] c0;
        int n;
        c0 = rx_cnt;
        for (n = 0; 16'(rx_cnt - c0) < k && n < 2000; n++) @(negedge core_clk);
        if (n >= 2000) begin num_errors++; give_verdict(); end
    endtask
    function automatic logic [15:0] enc(input logic [15:0] v, input logic [2:0] f);
        if (f[0]) v[15] = ~v[15];
        if (f[1]) v[15:1] = v[15:1] ^ {15{v[0]}};
        if (f[2]) v = v ^ 16'hAAAA;
        return v;
    endfunction
    task automatic t_regs();
        for (int i = 0; i < 3; i++) rd_cmp("config reset", 32'(4 * i), 32'h0);
        cmp("drive units", 32'h46, 32'(units));
        wr(32'(AOF_DATA_FMT_OFS), 32'h7);
        rd_cmp("format readback", 32'(AOF_DATA_FMT_OFS), 32'h7);
        wr(32'h40, 32'hFF);
        rd_cmp("unmapped read", 32'h40, 32'h0);
        wr(32'h104, 32'h3F);
        rd_cmp("aliased read", 32'h104, 32'h0);
        rd_cmp("aliased write", 32'(AOF_OUT_MODE_OFS), 32'h0);
    endtask
    task automatic t_code();
        logic [1:0] m [3] = '{2'b00, 2'b01, 2'b11};
        logic [15:0] ws [2] = '{16'hFFFF, 16'h8C35};
        for (int i = 0; i < 3; i++) begin
            wr(32'(AOF_OUT_MODE_OFS), 32'(m[i]));
            rx_ddr <= m[i][0];
            for (int f = 0; f < 8; f++) begin
                wr(32'(AOF_DATA_FMT_OFS), f);
                rx_fmt <= 3'(f);
                for (int j = 0; j < 2; j++) begin
                    @(posedge core_clk);
                    smp <= ws[j];
                    ovf <= j[0];
                    words(3);
                    cmp("coded", 32'(enc(ws[j], 3'(f))), 32'(rx_coded));
                    cmp("decoded", 32'(ws[j]), 32'(rx_raw));
                    cmp("overflow", 32'(j), 32'(rx_ovf));
                end
            end
            cmp("lvds mode", 32'(m[i] == 2'b11), 32'(lvds_mode));
        end
    endtask
    task automatic t_cur();
        for (int c = 0; c < 16; c++) begin
            wr(32'(AOF_OUT_MODE_OFS), 32'({c[3], c[2:0], 2'b11}));
            rd_cmp("mode readback", 32'(AOF_OUT_MODE_OFS), 32'({c[3], c[2:0], 2'b11}));
            @(negedge core_clk);
            cmp("termination", 32'(c[3]), 32'(term));
            cmp("drive units", 32'(AOF_CUR_TBL[c % 8]) << c[3], 32'(units));
        end
        wr(32'(AOF_OUT_MODE_OFS), 32'h0);
    endtask
    task automatic t_phase();
        logic [3:0] cc [4] = '{4'h0, 4'h4, 4'h5, 4'h8};
        int dl [4] = '{0, 0, 3, 0};
        int n;
        logic [15:0] prev;
        wr(32'(AOF_DATA_FMT_OFS), 32'h0);
        rx_ddr <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(32'(AOF_CLK_CTRL_OFS), 32'(cc[i]));
            words(2);
            @(posedge core_clk);
            smp <= ~smp;
            @(negedge core_clk);
            prev = data_out;
            for (n = 0; data_out === prev && n < 100; n++) @(negedge core_clk);
            for (n = 0; clk_t !== cc[i][3] && n < 20; n++) @(negedge core_clk);
            cmp("clock delay", 32'(dl[i]), 32'(n));
            cmp("stabilizer", 32'(cc[i][0]), 32'(dcs_en));
        end
    endtask
    task automatic t_strap();
        logic [31:0] q;
        // DDR CMOS, current code 1 and termination requested: all ignored in parallel config
        wr(32'(AOF_OUT_MODE_OFS), 32'h25);
        wr(32'(AOF_DATA_FMT_OFS), 32'h7);
        for (int l = 0; l < 2; l++) begin
            @(posedge core_clk);
            par <= 1'b1;
            lvds <= l[0];
            dcs <= l[0];
            rx_ddr <= l[0];
            rx_fmt <= 3'h0;
            smp <= 16'h1234;
            words(3);
            ahb(1'b0, 32'(AOF_STATUS_OFS), 32'h0, q);
            cmp("parallel flag", 32'h1, 32'(q[AOF_ST_PAR]));
            cmp("strap mode", (l != 0) ? 32'h3 : 32'h0, 32'(q[AOF_ST_MODE_LSB +: 2]));
            cmp("strap lvds", 32'(l), 32'(lvds_mode));
            cmp("strap stabilizer", 32'(l), 32'(dcs_en));
            cmp("strap termination", 32'h0, 32'(term));
            cmp("strap drive", 32'h46, 32'(units));
            cmp("strap coded", 32'h1234, 32'(rx_coded));
        end
    endtask
    task automatic t_test();
        wr(32'(AOF_DATA_FMT_OFS), 32'h7);
        @(posedge core_clk);
        tpw <= 16'h5A3C;
        tpe <= 1'b1;
        words(3);
        cmp("pattern", 32'h5A3C, 32'(rx_coded));
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        t_regs();
        t_code();
        t_cur();
        t_phase();
        t_strap();
        t_test();
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> testbench/aof_rx_model.sv
// Receiver model: captures the forwarded word and undoes the coding
`timescale 1ns/1ps
`default_nettype none
module aof_rx_model
    import aof_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Receiver setup
    input  wire logic        ddr,
    input  wire logic [2:0]  fmt,
    // Link pins
    input  wire logic [15:0] data_out,
    input  wire logic [7:0]  lanes,
    input  wire logic        ovf,
    input  wire logic        clk_t,
    // Captured result
    output logic      [15:0] rx_coded,
    output logic      [15:0] rx_raw,
    output logic             rx_ovf,
    output logic      [15:0] rx_cnt
);
    logic        clk_q;
    logic [7:0]  even;
    logic [15:0] w;
    // Pins are read one core cycle after each clock edge, once both halves have settled
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clk_q <= 1'b0;
            even <= '0;
            rx_coded <= '0;
            rx_ovf <= 1'b0;
            rx_cnt <= '0;
        end else begin
            clk_q <= clk_t;
            if (clk_q && !clk_t)
                even <= lanes;
            if (!clk_q && clk_t) begin
                for (int i = 0; i < 8; i++) begin
                    w[2*i] = even[i];
                    w[2*i+1] = lanes[i];
                end
                rx_coded <= ddr ? w : data_out;
                rx_ovf <= ovf;
                rx_cnt <= rx_cnt + 16'h1;
            end
        end
    end
    always_comb begin
        rx_raw = rx_coded;
        if (fmt[AOF_DF_ABP])
            rx_raw = rx_raw ^ AOF_ODD_MASK;
        if (fmt[AOF_DF_RAND])
            rx_raw[15:1] = rx_raw[15:1] ^ {15{rx_raw[0]}};
        if (fmt[AOF_DF_TWOS])
            rx_raw[15] = ~rx_raw[15];
    end
endmodule
`default_nettype wire
